// file: hdl/rpi_duty_map.v
// Signal level to duty step mapping
`timescale 1ns/1ps
module rpi_duty_map (
   // Level in
   input wire [7:0] level,
   // Steps out
   output reg [5:0] steps
);
`include "rpi_regs.vh"
   reg [7:0] margin;
   reg [9:0] num;
   reg [9:0] raw;
   always @* begin
      margin = 8'h00;
      num = 10'h000;
      raw = 10'h000;
      steps = 6'h00;
      // RL4 zero at sensitivity
      if (level > `RPI_SENS_LVL) begin
         margin = level - `RPI_SENS_LVL;
         // RL5 RL16 linear map
         // Steps = 13 + 0.6*dB, rounded: 10dB->19, 20dB->25, 30dB->31
         num = 10'd130 + {2'b00, margin} * 10'd6 + 10'd5;
         raw = num / 10'd10;
         // RL3 cap at 95 percent
         if (raw > `RPI_MAX_STEPS)
            steps = `RPI_MAX_STEPS;
         else
            steps = raw[5:0];
      end
   end
endmodule // rpi_duty_map

// file: hdl/rpi_pulse_ind.v
// Signal-strength pulse width indicator
// Behaviour
// RL1 - The pulse period is fixed at 8.32 ms between rising edges.
// RL2 - The high time is set in 40 steps of 0.208 ms each.
// RL3 - Duty is limited to between zero and 95 percent.
// RL4 - Duty is zero when the level is at or below sensitivity.
// RL5 - Duty is 47.5, 62.5 and 77.5 percent at 10, 20 and 30 dB margin.
// RL6 - The hold setting spans 0 to 0x7f in 100 ms units, 0 disables output.
// RL7 - A non-zero hold keeps the last packet duty active for the hold time.
// RL8 - When the hold expires without a packet the output stays low until one arrives.
// RL9 - The output is low at zero duty right after power-up.
// RL10 - Hold 0xff never times out and always shows the last packet.
// RL11 - The shared pin is an input at power-on and is sampled for command mode.
// RL12 - With non-zero hold the pin then becomes an output driven low until a packet.
// RL13 - The pin stays an input for hold-setting milliseconds after power-up.
// RL14 - The hold setting is read or written by command 0x22, a read gives one byte.
// RL15 - The packet level ranges 0x06 to 0x36, larger is stronger.
// RL16 - Between table points duty is linear near 1.5 percent per dB, capped.

`timescale 1ns/1ps
`include "rpi_regs.vh"

module rpi_pulse_ind #(
   parameter STEP_CYC = `RPI_STEP_CYC,
   parameter MS_CYC = `RPI_MS_CYC
) (
   // Clock and reset
   input wire core_clk,
   input wire rstn,
   // Command port
   input wire cmd_valid,
   input wire [7:0] cmd_code,
   input wire cmd_write,
   input wire [7:0] cmd_wdata,
   output reg rsp_valid,
   output reg [7:0] rsp_data,
   // Packet report
   input wire pkt_valid,
   input wire [7:0] pkt_level,
   // Shared pin
   input wire cfg_pin_i,
   output reg cfg_pin_o,
   output reg cfg_pin_oe,
   // Power-up sample
   output reg cmd_mode_req,
   output reg boot_done
);

   localparam ST_BOOT = 2'd0;
   localparam ST_IDLE = 2'd1;
   localparam ST_RUN = 2'd2;
   localparam ST_OFF = 2'd3;

   reg [1:0] st_q;
   reg [7:0] hold_q;
   reg [5:0] duty_q;
   reg [5:0] frame_q;
   reg [16:0] ms_cnt_q;
   reg [7:0] ms_q;
   reg [6:0] tenth_q;
   reg [31:0] step_cnt_q;
   reg [5:0] phase_q;

   wire [5:0] map_steps;
   wire step_tick;
   wire frame_end;
   wire ms_tick;
   wire [7:0] hold_in;

   // ****************************************
   // Level mapping
   // ****************************************
   rpi_duty_map u_map (
      .level(pkt_level),
      .steps(map_steps)
   );

   assign step_tick = (step_cnt_q == STEP_CYC - 1);
   // RL1 last frame step
   assign frame_end = step_tick && (phase_q == `RPI_STEPS - 1);
   assign ms_tick = (ms_cnt_q == MS_CYC[16:0] - 17'h00001);

   // RL6 RL10 legal hold values
   assign hold_in = (cmd_wdata == `RPI_HOLD_PERM || cmd_wdata <= `RPI_HOLD_MAX) ?
      cmd_wdata : `RPI_HOLD_MAX;

   // ****************************************
   // Command port
   // ****************************************
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hold_q <= `RPI_HOLD_RESET;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         rsp_valid <= 1'b0;
         // RL14 hold command access
         if (cmd_valid && cmd_code == `RPI_HOLD_CMD) begin
            rsp_valid <= 1'b1;
            if (cmd_write) begin
               hold_q <= hold_in;
               rsp_data <= hold_in;
            end else begin
               rsp_data <= hold_q;
            end
         end
      end
   end

   // ****************************************
   // Timebases
   // ****************************************
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ms_cnt_q <= 17'h00000;
         step_cnt_q <= 32'h00000000;
         phase_q <= 6'h00;
      end else begin
         ms_cnt_q <= ms_tick ? 17'h00000 : ms_cnt_q + 17'h00001;
         // RL1 RL2 period of 40 steps
         if (step_tick) begin
            step_cnt_q <= 32'h00000000;
            phase_q <= (phase_q == `RPI_STEPS - 1) ? 6'h00 : phase_q + 6'h01;
         end else begin
            step_cnt_q <= step_cnt_q + 32'h00000001;
         end
      end
   end

   // ****************************************
   // Frame latch
   // ****************************************
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         frame_q <= 6'h00;
      end else begin
         // RL1 new duty at frame start
         if (frame_end) begin
            frame_q <= (st_q == ST_RUN) ? duty_q : 6'h00;
         end
      end
   end

   // ****************************************
   // Control
   // ****************************************
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_BOOT;
         ms_q <= 8'h00;
         tenth_q <= 7'h00;
         duty_q <= 6'h00;
         cfg_pin_o <= 1'b0;
         cfg_pin_oe <= 1'b0;
         cmd_mode_req <= 1'b0;
         boot_done <= 1'b0;
      end else begin
         case (st_q)
            ST_BOOT: begin
               // RL11 sample pin as input
               cfg_pin_oe <= 1'b0;
               if (!boot_done) begin
                  cmd_mode_req <= cfg_pin_i;
                  boot_done <= 1'b1;
               end

               // RL13 stay input hold ms
               if (boot_done && ms_tick && ms_q != 8'hff) begin
                  ms_q <= ms_q + 8'h01;
               end
               if (boot_done && hold_q != 8'h00 && ms_q >= hold_q) begin
                  // RL12 convert to low output
                  st_q <= ST_IDLE;
                  cfg_pin_oe <= 1'b1;
                  cfg_pin_o <= 1'b0;
               end
            end

            ST_IDLE, ST_RUN, ST_OFF: begin
               // RL9 low until packet
               cfg_pin_oe <= 1'b1;
               if (pkt_valid) begin
                  // RL15 latest packet duty
                  duty_q <= map_steps;
                  st_q <= ST_RUN;
                  ms_q <= 8'h00;
                  tenth_q <= 7'h00;
               end else if (st_q == ST_RUN && hold_q != `RPI_HOLD_PERM) begin
                  // RL7 hold timer
                  if (ms_tick) begin
                     if (ms_q == `RPI_HOLD_UNIT_MS - 1) begin
                        ms_q <= 8'h00;
                        tenth_q <= tenth_q + 7'h01;
                     end else begin
                        ms_q <= ms_q + 8'h01;
                     end
                  end
                  // RL8 expire to constant low
                  if ({1'b0, tenth_q} >= hold_q) begin
                     st_q <= ST_OFF;
                     duty_q <= 6'h00;
                  end
               end

               // RL6 zero hold disables output
               if (hold_q == 8'h00) begin
                  st_q <= ST_OFF;
                  duty_q <= 6'h00;
               end

               // RL3 RL4 high for duty steps
               cfg_pin_o <= (phase_q < frame_q);
            end

            default: begin
               st_q <= ST_BOOT;
            end
         endcase
      end
   end
endmodule // rpi_pulse_ind

// file: hdl/rpi_regs.vh
// Constants for the signal-strength pulse indicator
`ifndef RPI_REGS_VH
`define RPI_REGS_VH
// ****************************************
// Timing
// ****************************************
`define RPI_CLK_HZ 100000000
`define RPI_STEP_NS 208000
`define RPI_STEP_CYC 20800
`define RPI_STEPS 40
`define RPI_MAX_STEPS 6'h26
`define RPI_MS_CYC 100000
`define RPI_HOLD_UNIT_MS 100
// ****************************************
// Hold setting
// ****************************************
`define RPI_HOLD_CMD 8'h22
`define RPI_HOLD_MAX 8'h7f
`define RPI_HOLD_PERM 8'hff
`define RPI_HOLD_RESET 8'h00
// ****************************************
// Signal level
// ****************************************
`define RPI_LVL_MIN 8'h06
`define RPI_LVL_MAX 8'h36
`define RPI_SENS_LVL 8'h06
`endif

// file: tb/rpi_meter_model.sv
// Meter that measures high time and period of the pin
`timescale 1ns/1ps
module rpi_meter_model (
   input wire clk, rstn, pin,
   output reg [15:0] hi, per,
   output reg vld
);
   reg [15:0] hc_q, pc_q;
   reg last_q;
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {hi, per, vld, hc_q, pc_q, last_q} <= 0;
      end else begin
         last_q <= pin;
         vld <= pin && !last_q;
         if (pin && !last_q) begin
            hi <= hc_q;
            per <= pc_q;
            hc_q <= 16'h0001;
            pc_q <= 16'h0001;
         end else begin
            hc_q <= hc_q + {15'h0, pin};
            pc_q <= pc_q + 16'h0001;
         end
      end
   end
endmodule // rpi_meter_model

// file: tb/rpi_pulse_ind_asserts.sv
// Port checker for the pulse indicator
`timescale 1ns/1ps
module rpi_pulse_ind_asserts #(parameter STEP_CYC = 20800) (
   input wire core_clk, rstn, cmd_valid, cmd_write, rsp_valid, pkt_valid,
   input wire [7:0] cmd_code, cmd_wdata, rsp_data, pkt_level,
   input wire cfg_pin_i, cfg_pin_o, cfg_pin_oe, cmd_mode_req, boot_done
);
   integer per_q, hi_q;
   reg seen_q;
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         per_q <= 0;
         hi_q <= 0;
         seen_q <= 1'b0;
      end else begin
         per_q <= $rose(cfg_pin_o) ? 1 : per_q + 1;
         hi_q <= cfg_pin_o ? hi_q + 1 : 0;
         seen_q <= seen_q | $rose(cfg_pin_o);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   ans_given_a: assert property (cmd_valid && cmd_code == 8'h22 |=> rsp_valid)
      else $error("no answer");
   other_code_a: assert property (cmd_valid && cmd_code != 8'h22 |=> !rsp_valid)
      else $error("answer to other code");
   write_echo_a: assert property (cmd_valid && cmd_code == 8'h22 && cmd_write &&
      cmd_wdata <= 8'h7f |=> rsp_data == $past(cmd_wdata)) else $error("bad echo");
   write_clip_a: assert property (cmd_valid && cmd_code == 8'h22 && cmd_write &&
      cmd_wdata > 8'h7f && cmd_wdata != 8'hff |=> rsp_data == 8'h7f) else $error("no clip");
   boot_sample_a: assert property (!boot_done |=> boot_done &&
      cmd_mode_req == $past(cfg_pin_i)) else $error("bad boot sample");
   pin_input_a: assert property (!boot_done |-> !cfg_pin_oe)
      else $error("pin driven at boot");
   drive_low_a: assert property ($rose(cfg_pin_oe) |-> !cfg_pin_o)
      else $error("pin not low");
   duty_cap_a: assert property (hi_q <= 38 * STEP_CYC)
      else $error("duty over cap");
   step_edge_a: assert property ($fell(cfg_pin_o) |-> hi_q % STEP_CYC == 0)
      else $error("high off step");
   frame_len_a: assert property ($rose(cfg_pin_o) && seen_q |->
      per_q % (40 * STEP_CYC) == 0) else $error("bad period");
   cover property (rsp_valid);
   cover property ($rose(cfg_pin_oe));
   cover property ($fell(cfg_pin_o));
endmodule // rpi_pulse_ind_asserts
bind rpi_pulse_ind rpi_pulse_ind_asserts #(.STEP_CYC(STEP_CYC)) u_chk (.core_clk, .rstn,
   .cmd_valid, .cmd_code, .cmd_write, .cmd_wdata, .rsp_valid, .rsp_data, .pkt_valid,
   .pkt_level, .cfg_pin_i, .cfg_pin_o, .cfg_pin_oe, .cmd_mode_req, .boot_done);

// file: tb/rpi_pulse_ind_tb.sv
// Testbench for the pulse indicator
`timescale 1ns/1ps
module rpi_pulse_ind_tb;
   localparam SC = 4;
   reg core_clk = 0, rstn = 0, cmd_valid = 0, cmd_write = 0, pkt_valid = 0, pin_drv = 0, boot;
   reg [7:0] cmd_code = 0, cmd_wdata = 0, pkt_level = 8'h06;
   reg [7:0] lv [0:4] = '{8'h06, 8'h10, 8'h1a, 8'h24, 8'h36};
   wire rsp_valid, cfg_pin_o, cfg_pin_oe, cmd_mode_req, boot_done, vld;
   wire [7:0] rsp_data;
   wire [15:0] hi, per;
   wire pin = cfg_pin_oe ? cfg_pin_o : pin_drv;
   integer failures = 0, compares = 0, seed = 32'h9a0338d6, cyc = 0, i, n, es;
   reg [7:0] rq [$];
   reg [15:0] dq [$];
   always #5 core_clk = ~core_clk;
   rpi_pulse_ind #(.STEP_CYC(SC), .MS_CYC(10)) i_dut (.core_clk, .rstn, .cmd_valid,
      .cmd_code, .cmd_write, .cmd_wdata, .rsp_valid, .rsp_data, .pkt_valid, .pkt_level,
      .cfg_pin_i(pin), .cfg_pin_o, .cfg_pin_oe, .cmd_mode_req, .boot_done);
   rpi_meter_model i_mtr (.clk(core_clk), .rstn, .pin, .hi, .per, .vld);
   task note(input ok);
      begin
         compares = compares + 1;
         if (!ok) begin
            failures = failures + 1;
            $display("MISMATCH %0t result differs", $time);
         end
      end
   endtask
   task chk_rsp(input [7:0] got, input [7:0] exp);
      note(got === exp);
   endtask
   task chk_duty(input [15:0] got, input [15:0] exp);
      note(got === exp);
   endtask
   task chk_time(input [15:0] got, input [15:0] exp);
      note(got === exp);
   endtask
   task cmd(input [7:0] c, input w, input [7:0] d, input [7:0] e);
      begin
         @(negedge core_clk);
         {cmd_valid, cmd_code, cmd_write, cmd_wdata} = {1'b1, c, w, d};
         if (c == 8'h22) rq.push_back(e);
         @(negedge core_clk);
         cmd_valid = 0;
      end
   endtask
   task pkt(input [7:0] l);
      begin
         es = (l <= 8'h06) ? 0 : (135 + 6 * (l - 6)) / 10;
         if (es > 38) es = 38;
         @(negedge core_clk);
         {pkt_valid, pkt_level} = {1'b1, l};
         @(negedge core_clk);
         pkt_valid = 0;
      end
   endtask
   task meas;
      begin
         repeat (330) @(negedge core_clk);
         n = 0;
         if (es) dq.push_back(16'(es * SC));
         else repeat (160) begin
            @(negedge core_clk);
            n = n + (cfg_pin_oe & cfg_pin_o);
         end
         if (!es) chk_duty(16'(n), 16'h0000);
         repeat (170) @(negedge core_clk);
      end
   endtask
   task report_and_stop;
      begin
         $display("failures %0d compares %0d", failures, compares);
         if (failures == 0 && compares > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   always @(negedge core_clk) begin
      if (rsp_valid === 1'b1)
         chk_rsp(rsp_data, rq.size() ? rq.pop_front() : ~rsp_data);
      if (vld === 1'b1 && dq.size() > 0) begin
         chk_duty(hi, dq.pop_front());
         chk_duty(per, 16'd160);
      end
   end
   always @(posedge core_clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         failures = failures + 1;
         report_and_stop;
      end
   end
   initial begin
      pin_drv = $random(seed);
      boot = pin_drv;
      repeat (10) @(negedge core_clk);
      rstn = 1;
      repeat (3) @(negedge core_clk);
      pin_drv = 1;
      chk_rsp({7'h0, cmd_mode_req}, {7'h0, boot});
      cmd(8'h23, 1, 8'h05, 8'h00);
      cmd(8'h22, 1, 8'h05, 8'h05);
      cmd(8'h22, 1, 8'h90, 8'h7f);
      cmd(8'h22, 0, 8'h00, 8'h7f);
      $display("test command done");
      cmd(8'h22, 1, 8'hff, 8'hff);
      wait (cfg_pin_oe === 1'b1);
      @(negedge core_clk);
      chk_time(16'(cyc / 10), 16'h0100);
      chk_rsp({7'h0, cfg_pin_o}, 8'h00);
      for (i = 0; i < 9; i = i + 1) begin
         pkt(i < 5 ? lv[i] : 8'(8'h06 + $unsigned($random(seed)) % 49));
         meas;
      end
      repeat (1500) @(negedge core_clk);
      meas;
      $display("test duty done");
      cmd(8'h22, 1, 8'h01, 8'h01);
      pkt(8'h24);
      meas;
      repeat (800) @(negedge core_clk);
      es = 0;
      meas;
      pkt(8'h1a);
      meas;
      $display("test timeout done");
      cmd(8'h22, 1, 8'h00, 8'h00);
      es = 0;
      meas;
      $display("test disable done");
      chk_rsp(8'(rq.size() + dq.size()), 8'h00);
      report_and_stop;
   end
endmodule // rpi_pulse_ind_tb
